// ---- lsd_pkg.sv ----
/*
   Constants shared by both ends of the LED sink shift-latch link.
   Assumes a 100 MHz core clock on each end; the link clock is sampled, not used as a clock.
*/
package lsd_pkg;
   localparam int          LSD_WORD_BITS     = 16;
   localparam int          LSD_TOP_BIT       = 15;
   localparam int          LSD_FAULT_A_BIT   = 14;
   localparam int          LSD_FAULT_B_BIT   = 13;
   localparam int          LSD_CLK_HZ        = 100_000_000;
   localparam int          LSD_WDOG_MS       = 1000;
   localparam int          LSD_WDOG_CYCLES   = LSD_CLK_HZ / 1000 * LSD_WDOG_MS;
   localparam int          LSD_CHECK_NS      = 100;
   localparam int          LSD_CHECK_CYCLES  = LSD_CHECK_NS * (LSD_CLK_HZ / 1_000_000) / 1000;
   localparam int          LSD_HALF_DIV      = 4;
   localparam logic [15:0] LSD_ZERO_WORD     = 16'h0000;
endpackage : lsd_pkg

// ---- lsd_link_if.sv ----
/*
   Pins between the host and the LED sink driver.
   Assumes both ends sit on one bench; the led pins resolve to the sink drive level here.
*/
`timescale 1ns/10ps
interface lsd_link_if;
   logic        serial_clk;
   logic        serial_in;
   logic        serial_out;
   logic        latch_load;
   logic        output_blank_n;
   logic [15:0] led_sink_o;
   logic [15:0] led_sink_oe;
   logic [15:0] led_open_fault;

   modport host
   (
      output serial_clk,
      output serial_in,
      input  serial_out,
      output latch_load,
      output output_blank_n
   );
   modport drv
   (
      input  serial_clk,
      input  serial_in,
      output serial_out,
      input  latch_load,
      input  output_blank_n,
      output led_sink_o,
      output led_sink_oe,
      input  led_open_fault
   );
endinterface : lsd_link_if

// ---- lsd_sync.sv ----
/*
   Two-flop synchroniser for a bundle of pin levels.
   Assumes inputs are asynchronous to i_core_clk.
*/
`timescale 1ns/10ps
module lsd_sync #(parameter int WIDTH = 1)
(
   input  wire logic             i_core_clk,
   input  wire logic             i_reset,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         meta_r <= '0;
         o_sync <= '0;
      end
      else
      begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule : lsd_sync

// ---- lsd_driver.sv ----
/*
   LED sink driver end: shift register, output latch, blanking, watchdog and open-circuit report.
   Assumes link pins arrive asynchronously and the bench supplies per-output open-circuit levels.
*/
`timescale 1ns/10ps
module lsd_driver
   import lsd_pkg::*;
#(
   parameter int WDOG_CYCLES = LSD_WDOG_CYCLES
)
(
   input  wire logic i_core_clk,
   input  wire logic i_reset,
   lsd_link_if.drv   link
);
   logic [3:0]  pins_s;
   logic [3:0]  pins_d_r;
   logic [15:0] open_s;
   logic [15:0] shift_r;
   logic [15:0] latch_r;
   logic        dout_r;
   logic [15:0] sink_o_r;
   logic [15:0] sink_oe_r;
   logic [31:0] wdog_r;
   logic [7:0]  chk_r;
   logic        fault_r;
   logic [1:0]  keep_r;
   logic        fault_in_r;

   lsd_sync #(.WIDTH(4)) u_pin_sync
   (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_async    ({link.serial_clk, link.serial_in, link.latch_load, link.output_blank_n}),
      .o_sync     (pins_s)
   );
   lsd_sync #(.WIDTH(16)) u_open_sync
   (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_async    (link.led_open_fault),
      .o_sync     (open_s)
   );

   wire sclk_s     = pins_s[3];
   wire sin_s      = pins_s[2];
   wire le_s       = pins_s[1];
   wire blank_n_s  = pins_s[0];
   wire sclk_rise  = sclk_s & ~pins_d_r[3];
   wire le_rise    = le_s & ~pins_d_r[1];
   wire blank_fall = ~blank_n_s & pins_d_r[0];
   wire activity   = |(pins_s[3:1] ^ pins_d_r[3:1]);
   wire wdog_fire  = (wdog_r == 32'(WDOG_CYCLES - 1));
   // Open: commanded on but sensed current below half
   wire any_open   = |(latch_r & open_s);
   // LED data bits stay in the latch while the fault bits wait to be shifted out
   wire [15:0] latch_src = fault_in_r ?
      {shift_r[LSD_TOP_BIT], keep_r, shift_r[LSD_FAULT_B_BIT-1:0]} : shift_r;

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         pins_d_r <= 4'h0;
      else
         pins_d_r <= pins_s;
   end

   // Shifting ignores blanking entirely
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         shift_r    <= LSD_ZERO_WORD;
         dout_r     <= 1'b0;
         keep_r     <= 2'h0;
         fault_in_r <= 1'b0;
      end
      else if (sclk_rise)
      begin
         shift_r    <= {shift_r[LSD_WORD_BITS-2:0], sin_s};
         dout_r     <= shift_r[LSD_TOP_BIT-1];
         fault_in_r <= 1'b0;
      end
      else if (le_rise)
      begin
         keep_r     <= fault_in_r ? keep_r : shift_r[LSD_FAULT_A_BIT:LSD_FAULT_B_BIT];
         fault_in_r <= 1'b1;
         shift_r[LSD_FAULT_A_BIT] <= fault_r;
         shift_r[LSD_FAULT_B_BIT] <= fault_r;
         dout_r                   <= shift_r[LSD_TOP_BIT];
      end
   end

   // Reset stands in for power-up; timeout clears latch only
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         latch_r <= LSD_ZERO_WORD;
      else if (le_s)
         latch_r <= latch_src;
      else if (wdog_fire)
         latch_r <= LSD_ZERO_WORD;
   end

   // Core-clock timebase counts with the link idle and holds at WDOG_CYCLES - 1 once it fires
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset || activity)
         wdog_r <= 32'h0000_0000;
      else if (!wdog_fire)
         wdog_r <= wdog_r + 32'h0000_0001;
   end

   // Sample fault a short settle time after blanking falls
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         chk_r   <= 8'h00;
         fault_r <= 1'b0;
      end
      else if (blank_fall)
         chk_r <= 8'(LSD_CHECK_CYCLES);
      else if (chk_r != 8'h00)
      begin
         chk_r <= chk_r - 8'h01;
         if (chk_r == 8'h01)
            fault_r <= any_open;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         sink_o_r  <= LSD_ZERO_WORD;
         sink_oe_r <= LSD_ZERO_WORD;
      end
      else
      begin
         sink_o_r  <= LSD_ZERO_WORD;
         sink_oe_r <= blank_n_s ? LSD_ZERO_WORD : latch_r;
      end
   end

   assign link.serial_out  = dout_r;
   assign link.led_sink_o  = sink_o_r;
   assign link.led_sink_oe = sink_oe_r;
endmodule : lsd_driver

// ---- lsd_host.sv ----
/*
   Host end: sends one 16-bit word MSB first on a divided link clock, then pulses latch_load,
   and captures the returned word for checking.
   Assumes the driver (or a cascade of them) sits on the link.
*/
`timescale 1ns/10ps
module lsd_host
   import lsd_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   input  wire logic        i_send,
   input  wire logic [15:0] i_word,
   input  wire logic        i_blank_n,
   output logic             o_busy,
   output logic             o_done,
   output logic [15:0]      o_rx_word,
   output logic             o_echo_ok,
   output logic             o_fault,
   lsd_link_if.host         link
);
   typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_LATCH} lsd_hstate_t;
   lsd_hstate_t state_r;
   logic [15:0] tx_r;
   logic [15:0] sent_r;
   logic [15:0] cur_r;
   logic [15:0] rx_r;
   logic [4:0]  bits_r;
   logic [3:0]  div_r;
   logic        sclk_r;
   logic        le_r;
   logic        blank_r;
   logic        dout_s;

   lsd_sync #(.WIDTH(1)) u_dout_sync
   (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_async    (link.serial_out),
      .o_sync     (dout_s)
   );

   wire div_end = (div_r == 4'(LSD_HALF_DIV - 1));
   wire last    = (bits_r == 5'(LSD_WORD_BITS - 1));
   wire [15:0] rx_full = {rx_r[14:0], dout_s};

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         state_r   <= H_IDLE;
         tx_r      <= LSD_ZERO_WORD;
         sent_r    <= LSD_ZERO_WORD;
         cur_r     <= LSD_ZERO_WORD;
         rx_r      <= LSD_ZERO_WORD;
         bits_r    <= 5'h00;
         div_r     <= 4'h0;
         sclk_r    <= 1'b0;
         le_r      <= 1'b0;
         blank_r   <= 1'b1;
         o_busy    <= 1'b0;
         o_done    <= 1'b0;
         o_rx_word <= LSD_ZERO_WORD;
         o_echo_ok <= 1'b0;
         o_fault   <= 1'b0;
      end
      else
      begin
         blank_r <= i_blank_n;
         o_done  <= 1'b0;
         div_r   <= div_end ? 4'h0 : div_r + 4'h1;
         unique case (state_r)
            H_IDLE:
               if (i_send)
               begin
                  tx_r    <= i_word;
                  cur_r   <= i_word;
                  bits_r  <= 5'h00;
                  div_r   <= 4'h0;
                  o_busy  <= 1'b1;
                  state_r <= H_LOW;
               end
            H_LOW:
               if (div_end)
               begin
                  sclk_r  <= 1'b1;
                  rx_r    <= rx_full; // Returned bits read at the edge the driver moves on
                  state_r <= H_HIGH;
               end
            H_HIGH:
               if (div_end)
               begin
                  sclk_r <= 1'b0;
                  tx_r   <= {tx_r[14:0], 1'b0};
                  bits_r <= bits_r + 5'h01;
                  state_r <= last ? H_LATCH : H_LOW;
               end
            H_LATCH:
               if (div_end)
               begin
                  le_r <= ~le_r;
                  if (le_r)
                  begin
                     state_r   <= H_IDLE;
                     o_busy    <= 1'b0;
                     o_done    <= 1'b1;
                     o_rx_word <= rx_r;
                     // Echo on all but fault bits; fault valid only if both agree
                     o_echo_ok <= ((rx_r ^ sent_r) & 16'h9FFF) == LSD_ZERO_WORD;
                     o_fault   <= rx_r[LSD_FAULT_A_BIT] & rx_r[LSD_FAULT_B_BIT];
                     // Returned word is the one sent last time, so keep it one transfer
                     sent_r    <= cur_r;
                  end
               end
         endcase
      end
   end

   assign link.serial_clk     = sclk_r;
   assign link.serial_in      = tx_r[LSD_TOP_BIT];
   assign link.latch_load     = le_r;
   assign link.output_blank_n = blank_r;
endmodule : lsd_host

// ---- lsd_checker.sv ----
/*
   Checker on the LED sink link pins, beside the interface.
   Assumes one core clock for both ends and link edges at least 4 cycles apart.
*/
`timescale 1ns/10ps
module lsd_checker #(parameter int WDOG_CYCLES = 200)
(
   input wire logic        i_core_clk,
   input wire logic        i_reset,
   input wire logic        serial_clk,
   input wire logic        serial_in,
   input wire logic        serial_out,
   input wire logic        latch_load,
   input wire logic        output_blank_n,
   input wire logic [15:0] led_sink_o,
   input wire logic [15:0] led_sink_oe
);
   logic [2:0]  pin_r;
   logic [31:0] quiet_r;
   logic [3:0]  since_r;
   logic [15:0] sh_r;
   logic [15:0] vm_r;
   wire  [2:0]  pin_now  = {serial_clk, serial_in, latch_load};
   wire         clk_rise = serial_clk & ~pin_r[2];
   wire         le_rise  = latch_load & ~pin_r[0];
   wire         act      = |(pin_now ^ pin_r);
   wire  [15:0] sh_nxt   = clk_rise ? {sh_r[14:0], serial_in} : sh_r;
   // Fault bits cannot be seen on the pins, so they are masked after a load
   wire  [15:0] vm_nxt   = clk_rise ? {vm_r[14:0], 1'h1} : le_rise ? (vm_r & 16'h9FFF) : vm_r;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);

   always_ff @(posedge i_core_clk)
   begin
      pin_r   <= pin_now;
      sh_r    <= sh_nxt;
      quiet_r <= (i_reset || act) ? 32'h0 : quiet_r + 32'h1;
      since_r <= (i_reset || clk_rise || le_rise) ? 4'h0 : since_r + {3'h0, ~&since_r};
      vm_r    <= i_reset ? 16'h0000 : vm_nxt;
   end

   AST_SINK_LOW:
   assert property (led_sink_o == 16'h0000) else $error("sink level not low");
   AST_BLANK_OFF:
   assert property (output_blank_n [*5] |-> led_sink_oe == 16'h0000)
      else $error("output on while blanked");
   // Margin of 4 covers the driver's synchroniser lag behind these raw pins
   AST_LATCH_HOLD:
   assert property ((!latch_load && !output_blank_n) [*8] ##0 (quiet_r < WDOG_CYCLES - 4)
      |-> $stable(led_sink_oe)) else $error("outputs moved while latch held");
   AST_WDOG_CLEAR:
   assert property ((quiet_r > WDOG_CYCLES + 12) && !latch_load |-> led_sink_oe == 16'h0000)
      else $error("outputs on after quiet link");
   AST_OUT_CAUSE:
   assert property ($changed(serial_out) |-> since_r <= 4'h6)
      else $error("serial out moved without clock");
   AST_SHIFT_OUT:
   assert property (clk_rise |-> ##6 (!vm_r[15] || serial_out == sh_r[15]))
      else $error("serial out wrong after shift");
   AST_LE_TOP:
   assert property (le_rise |-> ##6 (!vm_r[15] || serial_out == sh_r[15]))
      else $error("top bit not shown after load");
   AST_RESET_OFF:
   assert property (disable iff (1'h0) i_reset |=> led_sink_oe == 16'h0000)
      else $error("outputs on after reset");
endmodule : lsd_checker

// ---- tb_led_sink_shift_latch_driver.sv ----
/*
   Self-checking bench: host and driver joined by the link; open-circuit levels come from here.
   Assumes the host pulses o_done once per word in the same cycle latch_load falls.
*/
`timescale 1ns/10ps
module tb_led_sink_shift_latch_driver;
   localparam int WDOG = 200;
   logic        i_core_clk;
   logic        i_reset;
   logic        go;
   logic [15:0] word;
   logic        blank_n;
   logic        done;
   logic        busy;
   logic [15:0] rx_word;
   logic        echo_ok;
   logic        fault;
   logic [15:0] open_mask;
   logic [15:0] lw;
   logic [15:0] wv;
   logic [15:0] latch_m;
   logic        lf;
   logic        fault_now;
   logic        have;
   logic        seen;
   logic [17:0] exp_q[$];
   int          error_cnt;
   int          num_checks;
   int          cyc;
   int          seed;

   lsd_link_if link ();
   assign link.led_open_fault = open_mask;

   lsd_host u_lsd_host
   (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_send     (go),
      .i_word     (word),
      .i_blank_n  (blank_n),
      .o_busy     (busy),
      .o_done     (done),
      .o_rx_word  (rx_word),
      .o_echo_ok  (echo_ok),
      .o_fault    (fault),
      .link       (link.host)
   );
   lsd_driver #(.WDOG_CYCLES(WDOG)) u_lsd_driver
   (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .link       (link.drv)
   );
   lsd_checker #(.WDOG_CYCLES(WDOG)) u_lsd_checker
   (
      .i_core_clk     (i_core_clk),
      .i_reset        (i_reset),
      .serial_clk     (link.serial_clk),
      .serial_in      (link.serial_in),
      .serial_out     (link.serial_out),
      .latch_load     (link.latch_load),
      .output_blank_n (link.output_blank_n),
      .led_sink_o     (link.led_sink_o),
      .led_sink_oe    (link.led_sink_oe)
   );

   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask : tick

   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wrap_up;
      if (error_cnt == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   // Always called high then low, so every low call is a falling edge
   task automatic set_blank(input logic b);
      blank_n = b;
      if (!b)
         fault_now = |(latch_m & open_mask);
      tick(20);
      check({2'h0, link.led_sink_oe}, b ? 18'h0 : {2'h0, latch_m});
   endtask : set_blank

   task automatic send(input logic [15:0] w);
      if (have)
         exp_q.push_back({1'h1, lf, lw[15], lf, lf, lw[12:0]});
      go = 1'h1;
      word = w;
      tick(1);
      go = 1'h0;
      check({17'h0, busy}, 18'h1);
      while (done !== 1'h1)
         tick(1);
      check({17'h0, busy}, 18'h0);
      tick(1);
      lw = w;
      lf = fault_now;
      latch_m = w;
      have = 1'h1;
   endtask : send

   always @(posedge i_core_clk)
      if (done === 1'h1)
      begin
         if (seen)
            check({echo_ok, fault, rx_word}, exp_q.pop_front());
         seen = 1'h1;
      end

   always @(posedge i_core_clk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         error_cnt++;
         wrap_up();
      end
   end

   initial
   begin
      i_core_clk = 1'h0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   initial
   begin
      seed = 67224;
      i_reset = 1'h1;
      go = 1'h0;
      word = 16'h0000;
      blank_n = 1'h1;
      open_mask = 16'h0000;
      fault_now = 1'h0;
      have = 1'h0;
      seen = 1'h0;
      error_cnt = 0;
      num_checks = 0;
      cyc = 0;
      tick(16);
      i_reset = 1'h0;
      check({2'h0, link.led_sink_oe}, 18'h0);
      send(16'($random(seed)));
      set_blank(1'h1);
      set_blank(1'h0);
      for (int i = 0; i < 8; i++)
      begin
         wv = 16'($random(seed));
         send(wv);
         // Odd passes open only unlit outputs, which must not report
         open_mask = i[0] ? ~wv : (16'($random(seed)) | wv);
         set_blank(1'h1);
         set_blank(1'h0);
      end
      tick(WDOG + 40);
      latch_m = 16'h0000;
      check({2'h0, link.led_sink_oe}, 18'h0);
      send(16'hA5C3);
      tick(20);
      check({2'h0, link.led_sink_oe}, 18'h0A5C3);
      send(16'h5A3C);
      tick(10);
      wrap_up();
   end
endmodule : tb_led_sink_shift_latch_driver
